// [power_on_strap_capture_tb.sv]
`timescale 1ns/1ns
module power_on_strap_capture_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [26:0] userLevels = 27'h0;
    logic [26:0] lines;
    logic [31:0] prdata;
    logic pready, pslverr, strapsValid, pciClockOutput;
    logic [2:0] hostPllCode;
    psc_pkg::psc_pll_freq_e hostPllFreq;
    logic [7:0] lastLow;
    int failures = 0;
    int comparisons = 0;
    initial forever #10 clk = ~clk;
    psc_board_straps u_board (.userLevels(userLevels), .memoryDataStrapLines(lines));
    psc_strap_capture u_dut (.clk(clk), .resetn(resetn), .memoryDataStrapLines(lines),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .strapsValid(strapsValid),
        .pciClockOutput(pciClockOutput), .hostPllCode(hostPllCode), .hostPllFreq(hostPllFreq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, output logic [31:0] d, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= 32'hFFFFFFFF;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // a slave that never answers counts as a mismatch
        if (pready !== 1'b1)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, pready, 1'b1);
        end
        d = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic t_capture(input int i);
        logic [26:0] v;
        logic [31:0] d;
        logic e;
        int hi;
        v = 27'(32'h5A3C96 * (i + 1));
        v[26:24] = i[2:0]; v[23:21] = 3'h7; v[17] = i[0];
        userLevels <= v; resetn <= 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        // lines move after capture and must not be seen
        userLevels <= ~v;
        lastLow = v[7:0];
        apb(1'b0, 12'h128, d, e); chk(d, {24'h0, v[7:0]});
        chk({31'h0, e}, 32'h0);
        apb(1'b0, 12'h12C, d, e); chk(d, {24'h0, v[15:8]});
        apb(1'b0, 12'h130, d, e); chk(d, {27'h0, v[20:16]});
        apb(1'b0, 12'h17C, d, e); chk(d, {26'h0, v[26:21]});
        chk({29'h0, hostPllCode}, 32'(i));
        chk({29'h0, hostPllFreq}, i < 3 ? 32'h0 : 32'(i - 2));
        hi = 0;
        repeat (12) @(posedge clk) hi += (pciClockOutput === 1'b1);
        chk(hi, i[0] ? 32'h4 : 32'h6);
    endtask
    task automatic t_refuse;
        logic [31:0] d;
        logic e;
        apb(1'b1, 12'h128, d, e); chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h128, d, e); chk(d, {24'h0, lastLow});
        apb(1'b0, 12'h134, d, e); chk({31'h0, e}, 32'h1);
        chk(d, 32'h0);
    endtask
    initial
    begin
        for (int i = 0; i < 8; i++) t_capture(i);
        t_refuse();
        finish_test();
    end
    initial
    begin
        #100000;
        failures++;
        finish_test();
    end
endmodule

// [psc_board_straps.sv]
`timescale 1ns/1ns
// ==========
// board strap resistors
module psc_board_straps
(
    // jumper levels
    input wire logic [psc_pkg::STRAP_W-1:0] userLevels,
    // lines seen by the device
    output logic [psc_pkg::STRAP_W-1:0] memoryDataStrapLines
);
    assign memoryDataStrapLines[26:24] = userLevels[26:24];
    assign memoryDataStrapLines[23:21] = 3'h7;
    assign memoryDataStrapLines[20:0] = userLevels[20:0];
endmodule

// [psc_pkg.sv]
// ==========================================================
// strap capture constants
package psc_pkg;

    // ==========================================================
    // apb
    localparam int APB_DATA_W = 32;
    localparam int APB_ADDR_W = 12;
    localparam int WORD_SHIFT = 2;

    // register indices; the byte address is the index times four
    localparam logic [7:0] IDX_SIMM_LOW = 8'h4A;
    localparam logic [7:0] IDX_SIMM_HIGH = 8'h4B;
    localparam logic [7:0] IDX_CLK_DIV = 8'h4C;
    localparam logic [7:0] IDX_HOST_PLL = 8'h5F;

    // ==========================================================
    // strap line ranges
    localparam int STRAP_W = 27;
    localparam int LOW_LSB = 0;
    localparam int HIGH_LSB = 8;
    localparam int DIV_LSB = 16;
    localparam int DIV_W = 5;
    localparam int PLL_LSB = 21;
    localparam int PLL_W = 6;
    localparam int CFG_W = 8;

    // ==========================================================
    // fields
    localparam int DIV_SEL_BIT = 1;
    localparam int PLL_CODE_LSB = 3;
    localparam int PLL_CODE_W = 3;
    localparam logic [2:0] PLL_CODE_25 = 3'h3;
    localparam logic [2:0] PLL_CODE_50 = 3'h4;
    localparam logic [2:0] PLL_CODE_60 = 3'h5;
    localparam logic [2:0] PLL_CODE_66 = 3'h6;
    localparam logic [2:0] PLL_CODE_75 = 3'h7;

    // pci clock divisors, as a terminal count of a 2-bit counter
    localparam logic [1:0] DIV2_LAST = 2'h1;
    localparam logic [1:0] DIV3_LAST = 2'h2;

    // ==========================================================
    // types
    typedef struct packed {
        logic [7:0] simmLow;
        logic [7:0] simmHigh;
        logic [4:0] clkDiv;
        logic [5:0] hostPll;
    } psc_straps_s;

    typedef enum logic [2:0] {
        PLL_RESERVED,
        PLL_25MHZ,
        PLL_50MHZ,
        PLL_60MHZ,
        PLL_66MHZ,
        PLL_75MHZ
    } psc_pll_freq_e;

endpackage

// [psc_strap_capture.sv]
`timescale 1ns/1ns
module psc_strap_capture #(
    parameter int ADDR_W = psc_pkg::APB_ADDR_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // board strap levels on the memory data lines
    input wire logic [psc_pkg::STRAP_W-1:0] memoryDataStrapLines,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [psc_pkg::APB_DATA_W-1:0] pwdata,
    output logic [psc_pkg::APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // clocking controls
    output logic strapsValid,
    output logic pciClockOutput,
    output logic [psc_pkg::PLL_CODE_W-1:0] hostPllCode,
    output psc_pkg::psc_pll_freq_e hostPllFreq
);

    // ==========================================================
    // parameter check
    generate
        if (ADDR_W < 10)
        begin : gAddrCheck
            $error("ADDR_W too small for the strap register map");
        end
    endgenerate

    // ==========================================================
    // capture
    psc_pkg::psc_straps_s straps_ff;
    logic captured_ff;

    // async reset only loads constants, so the straps are caught at the
    // first edge after release while the board still presents them
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            captured_ff <= 1'b0;
            straps_ff <= '0;
        end
        else if (!captured_ff)
        begin
            captured_ff <= 1'b1;
            straps_ff.simmLow <= memoryDataStrapLines[psc_pkg::LOW_LSB +: psc_pkg::CFG_W];
            straps_ff.simmHigh <= memoryDataStrapLines[psc_pkg::HIGH_LSB +: psc_pkg::CFG_W];
            straps_ff.clkDiv <= memoryDataStrapLines[psc_pkg::DIV_LSB +: psc_pkg::DIV_W];
            straps_ff.hostPll <= memoryDataStrapLines[psc_pkg::PLL_LSB +: psc_pkg::PLL_W];
        end
    end
    // lines above bit 26 are not even ports: nothing may hang off them

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            strapsValid <= 1'b0;
        else
            strapsValid <= captured_ff;
    end

    // ==========================================================
    // pci clock output divider
    // simm bits (lines 15..0) feed only the read path, never DRAM timing
    logic [1:0] divCnt_ff;
    logic [1:0] divLast;

    assign divLast = straps_ff.clkDiv[psc_pkg::DIV_SEL_BIT] ?
        psc_pkg::DIV3_LAST : psc_pkg::DIV2_LAST;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            divCnt_ff <= 2'h0;
        else if (!captured_ff || divCnt_ff >= divLast)
            divCnt_ff <= 2'h0;
        else
            divCnt_ff <= divCnt_ff + 2'h1;
    end

    // high for the first cycle of each period; duty is 1/2 or 1/3
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pciClockOutput <= 1'b0;
        else
            pciClockOutput <= captured_ff && (divCnt_ff == 2'h0);
    end

    // ==========================================================
    // host synthesizer select
    logic [psc_pkg::PLL_CODE_W-1:0] pllCode;
    psc_pkg::psc_pll_freq_e nxt_pllFreq;

    assign pllCode = straps_ff.hostPll[psc_pkg::PLL_CODE_LSB +: psc_pkg::PLL_CODE_W];

    always_comb
    begin
        case (pllCode)
            psc_pkg::PLL_CODE_25: nxt_pllFreq = psc_pkg::PLL_25MHZ;
            psc_pkg::PLL_CODE_50: nxt_pllFreq = psc_pkg::PLL_50MHZ;
            psc_pkg::PLL_CODE_60: nxt_pllFreq = psc_pkg::PLL_60MHZ;
            psc_pkg::PLL_CODE_66: nxt_pllFreq = psc_pkg::PLL_66MHZ;
            psc_pkg::PLL_CODE_75: nxt_pllFreq = psc_pkg::PLL_75MHZ;
            default: nxt_pllFreq = psc_pkg::PLL_RESERVED;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hostPllCode <= '0;
            hostPllFreq <= psc_pkg::PLL_RESERVED;
        end
        else
        begin
            hostPllCode <= pllCode;
            hostPllFreq <= nxt_pllFreq;
        end
    end

    // ==========================================================
    // apb register read
    logic [ADDR_W-psc_pkg::WORD_SHIFT-1:0] wordIdx;
    logic hit;
    logic [psc_pkg::CFG_W-1:0] rdByte;
    logic setup;

    assign wordIdx = paddr[ADDR_W-1:psc_pkg::WORD_SHIFT];
    assign setup = psel && !penable;

    always_comb
    begin
        hit = 1'b1;
        rdByte = '0;
        case (wordIdx)
            (ADDR_W-psc_pkg::WORD_SHIFT)'(psc_pkg::IDX_SIMM_LOW): rdByte = straps_ff.simmLow;
            (ADDR_W-psc_pkg::WORD_SHIFT)'(psc_pkg::IDX_SIMM_HIGH): rdByte = straps_ff.simmHigh;
            (ADDR_W-psc_pkg::WORD_SHIFT)'(psc_pkg::IDX_CLK_DIV): rdByte = {3'h0, straps_ff.clkDiv};
            (ADDR_W-psc_pkg::WORD_SHIFT)'(psc_pkg::IDX_HOST_PLL): rdByte = {2'h0, straps_ff.hostPll};
            default: hit = 1'b0;
        endcase
    end

    // answer lands one cycle after setup; writes are refused, registers stay
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && (pwrite || !hit);
            if (setup && !pwrite && hit)
                prdata <= {{(psc_pkg::APB_DATA_W-psc_pkg::CFG_W){1'b0}}, rdByte};
            else
                prdata <= '0;
        end
    end

    // pwdata is accepted on the bus but nothing here is writable
    logic unusedWdata;
    assign unusedWdata = ^pwdata;

endmodule

// [psc_strap_capture_sva.sv]
`timescale 1ns/1ns
// ==========
// strap capture checks
module psc_strap_capture_sva #(
    parameter int ADDR_W = 12
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // clocking
    input wire logic strapsValid,
    input wire logic pciClockOutput,
    input wire logic [2:0] hostPllCode,
    input wire psc_pkg::psc_pll_freq_e hostPllFreq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic setup;
    assign setup = psel && !penable;
    property p_answer; setup |=> pready && penable; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_idle; !psel |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("stray ready");
    property p_refuse; setup && pwrite |=> pslverr; endproperty
    a_refuse: assert property (p_refuse) else $error("write accepted");
    property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_pllread; setup && paddr == 12'h17C |=> prdata[5:3] == hostPllCode; endproperty
    a_pllread: assert property (p_pllread) else $error("pll code mismatch");
    property p_hold; strapsValid && $past(strapsValid) |-> $stable(hostPllCode); endproperty
    a_hold: assert property (p_hold) else $error("pll code moved");
    property p_freq;
        strapsValid |-> hostPllFreq == (hostPllCode < 3'h3 ? psc_pkg::PLL_RESERVED
            : psc_pkg::psc_pll_freq_e'(hostPllCode - 3'h2));
    endproperty
    a_freq: assert property (p_freq) else $error("bad frequency");
    property p_pulse; $rose(pciClockOutput) |=> !pciClockOutput; endproperty
    a_pulse: assert property (p_pulse) else $error("long pci pulse");
    property p_period; strapsValid && $rose(pciClockOutput) |-> ##[2:3] $rose(pciClockOutput); endproperty
    a_period: assert property (p_period) else $error("pci period");
    property p_unmapped; setup && paddr == 12'h134 |=> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    c_write: cover property (setup && pwrite);
    c_pll: cover property (setup && paddr == 12'h17C);
    c_pci: cover property ($rose(pciClockOutput));
endmodule
bind psc_strap_capture psc_strap_capture_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
